// ==== shared/evpc_map.svh ====
// offsets, field positions, reset values, vectors and counts of the block
`ifndef EVPC_MAP_SVH
`define EVPC_MAP_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define EVPC_OFF_CTRL 4'h0
`define EVPC_OFF_PRIO 4'h4
`define EVPC_OFF_STAT 4'h8

// -----------------------------------------------------------------
// irq_control_reg field positions
// -----------------------------------------------------------------
`define EVPC_BIT_EDGE 7
`define EVPC_BIT_CONN 6
`define EVPC_BIT_DLY 5

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define EVPC_RST_EDGE 1'b0
`define EVPC_RST_CONN 1'b1
`define EVPC_RST_DLY 1'b1
`define EVPC_RST_PRIO 8'hf2

// -----------------------------------------------------------------
// vectors and maskable slot layout
// -----------------------------------------------------------------
`define EVPC_VEC_RESET 16'hfffe
`define EVPC_VEC_CLKMON 16'hfffc
`define EVPC_VEC_WDOG 16'hfffa
`define EVPC_VEC_TRAP 16'hfff8
`define EVPC_VEC_NMI 16'hfff4
`define EVPC_VEC_PAGE 8'hff
`define EVPC_MASK_TOP 8'hf2
`define EVPC_MASK_LOW 8'hd0
`define EVPC_MASK_RSVD 8'hd4
`define EVPC_NSLOT 18
`define EVPC_SLOT_SCI 14

// -----------------------------------------------------------------
// timing counts
// -----------------------------------------------------------------
`define EVPC_STOP_DLY_CYC 4096

`endif

// ==== shared/evpc_pkg.sv ====
// types and decode functions of the exception vector block
`default_nettype none
`include "evpc_map.svh"
package evpc_pkg;
  // phases of one interrupt vector hand-out
  typedef enum logic [0:0] {SEQ_IDLE, SEQ_HOLD} evpc_seq_t;

  // avalon-mm request bundle from the master
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } evpc_bus_req_t;

  // avalon-mm answer bundle to the master
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } evpc_bus_rsp_t;

  // state of the external request pin latch
  typedef struct packed {
    logic pin_prev;
    logic edge_hit;
  } evpc_latch_st_t;

  // state of the main controller
  typedef struct packed {
    logic edge_only;
    logic connect;
    logic dly;
    logic edge_wr_seen;
    logic dly_wr_seen;
    logic [7:0] prio;
    logic waitreq;
    logic [31:0] rdata;
    evpc_seq_t seq;
    logic [15:0] vec;
    logic vec_valid;
    logic sel_pin;
    logic int_req;
    logic [12:0] dly_cnt;
    logic osc_stable;
    logic booted;
    logic [15:0] rst_vec;
  } evpc_st_t;

  // true when a low vector byte names an implemented maskable slot
  function automatic logic evpc_slot_ok(input logic [7:0] b);
    evpc_slot_ok = !b[0] && b >= `EVPC_MASK_LOW &&
                   b <= `EVPC_MASK_TOP && b != `EVPC_MASK_RSVD;
  endfunction : evpc_slot_ok

  // slot index of a low vector byte, slot 0 is the top vector
  function automatic logic [4:0] evpc_slot_of(input logic [7:0] b);
    logic [7:0] d;
    d = `EVPC_MASK_TOP - b;
    evpc_slot_of = d[5:1];
  endfunction : evpc_slot_of
endpackage : evpc_pkg
`default_nettype wire

// ==== src/evpc_irq_latch.sv ====
// external maskable request pin: level or falling-edge capture
`default_nettype none
module evpc_irq_latch
  import evpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pin_n,
  input wire logic edge_mode,
  input wire logic connect,
  input wire logic clear,
  output logic req
);
  import evpc_pkg::*;

  evpc_latch_st_t st_r; // registered state
  evpc_latch_st_t st_nxt; // next state
  logic fall; // falling edge seen this cycle

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pin_prev = pin_n;
    fall = st_r.pin_prev && !pin_n;
    // service clears the latch; a new edge in the same cycle wins
    if (clear)
    begin
      st_nxt.edge_hit = 1'b0;
    end
    if (fall && connect && edge_mode)
    begin
      st_nxt.edge_hit = 1'b1;
    end
    // leaving edge mode drops any stale capture
    if (!edge_mode)
    begin
      st_nxt.edge_hit = 1'b0;
    end
  end

  // level mode relies on the outside holding the pin until serviced
  assign req = connect && (edge_mode ? st_r.edge_hit : !pin_n);

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_r <= '{pin_prev: 1'b1, edge_hit: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
endmodule : evpc_irq_latch
`default_nettype wire

// ==== src/evpc_prio_pick.sv ====
// maskable source priority pick with one promoted slot
`default_nettype none
`include "evpc_map.svh"
module evpc_prio_pick
  import evpc_pkg::*;
#(
  parameter int NSLOT = `EVPC_NSLOT
)
(
  input wire logic [NSLOT-1:0] pend,
  input wire logic [7:0] promo,
  output logic hit,
  output logic [7:0] vec_lo
);
  import evpc_pkg::*;

  logic [4:0] pslot; // slot that software promoted

  // -----------------------------------------------------------------
  // pick: promoted slot first, then highest vector address
  // -----------------------------------------------------------------
  always_comb
  begin
    hit = 1'b0;
    vec_lo = `EVPC_MASK_TOP;
    // unusable promotion values fall back to the pin slot
    pslot = evpc_slot_ok(promo) ? evpc_slot_of(promo) : 5'h00;
    // descending loop so the lowest slot is the last to win
    for (int i = NSLOT - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        hit = 1'b1;
        vec_lo = `EVPC_MASK_TOP - 8'(2 * i);
      end
    end
    // promotion leaves the order of the others untouched
    if (pend[pslot])
    begin
      vec_lo = `EVPC_MASK_TOP - {2'h0, pslot, 1'b0};
    end
  end
endmodule : evpc_prio_pick
`default_nettype wire

// ==== src/evpc_ctrl.sv ====
// exception vector, masking and priority controller with avalon slave
// Notes on behaviour
// - fixed vectors for clock, watchdog, nmi pin
// - maskable needs I clear and local enable
// - four serial enables share one vector
// - nmi pin level; request pin may be level
// - nothing pending at start gives trap vector
// - edge latch held, cleared on service
// - other requests pend until their flag clears
// - edge select writable once in normal modes
// - special modes skip first edge select write
// - connect bit writable always, gates the pin
// - stop delay bit once normal, always special
// - stop delay bit waits 4096 cycles
// - priority writes only while I bit set
// - bad promotion value makes pin top
// - power and pin reset share normal vector
// - reset entry and release both wait for a clock edge
// - reset loads promotion register with f2
// - maskable only while I clear, set at reset
`default_nettype none
`include "evpc_map.svh"
module evpc_ctrl
  import evpc_pkg::*;
#(
  parameter int NSLOT = `EVPC_NSLOT,
  parameter int STOP_DLY = `EVPC_STOP_DLY_CYC
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire evpc_pkg::evpc_bus_req_t avm_req,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  input wire logic special_mode,
  input wire logic cpu_i_bit,
  input wire logic cpu_x_bit,
  input wire logic ext_request_n,
  input wire logic nonmaskable_request_pin_n,
  input wire logic [NSLOT-1:1] periph_flag,
  input wire logic [NSLOT-1:1] periph_en,
  input wire logic [3:0] sci_flag,
  input wire logic [3:0] sci_en,
  input wire logic seq_start,
  input wire logic vec_done,
  input wire logic stop_exit,
  input wire logic rst_cause_clkmon,
  input wire logic rst_cause_wdog,
  output logic int_req,
  output logic [15:0] vec_addr,
  output logic vec_valid,
  output logic [15:0] reset_vec,
  output logic osc_stable
);
  import evpc_pkg::*;

  // -----------------------------------------------------------------
  // state and reset image
  // -----------------------------------------------------------------
  localparam evpc_st_t ST_RST = '{
    edge_only: `EVPC_RST_EDGE,
    connect: `EVPC_RST_CONN,
    dly: `EVPC_RST_DLY,
    edge_wr_seen: 1'b0,
    dly_wr_seen: 1'b0,
    prio: `EVPC_RST_PRIO,
    waitreq: 1'b1,
    rdata: 32'h0000_0000,
    seq: SEQ_IDLE,
    vec: `EVPC_VEC_RESET,
    vec_valid: 1'b0,
    sel_pin: 1'b0,
    int_req: 1'b0,
    dly_cnt: 13'h0000,
    osc_stable: 1'b1,
    booted: 1'b0,
    rst_vec: `EVPC_VEC_RESET
  };

  evpc_st_t st_r; // registered state
  evpc_st_t st_nxt; // next state
  logic pin_req; // pin request after latch and connect
  logic pin_clr; // service of a pin vector
  logic [NSLOT-1:0] pend; // gated maskable requests
  logic m_hit; // some maskable source is enabled and pending
  logic [7:0] m_lo; // low byte of chosen maskable vector
  logic nmi_act; // nonmaskable pin asking and not masked
  logic bus_req; // master holds a request
  logic wr_ack; // write takes effect this edge
  logic [31:0] rd_mux; // read value of addressed register
  logic [7:0] wd; // write byte lane 0

  // -----------------------------------------------------------------
  // external pin latch and maskable pick
  // -----------------------------------------------------------------
  evpc_irq_latch u_latch (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_n(ext_request_n),
    .edge_mode(st_r.edge_only),
    .connect(st_r.connect),
    .clear(pin_clr),
    .req(pin_req)
  );

  // each slot needs its flag, its enable and a clear I bit
  always_comb
  begin
    pend = '0;
    pend[0] = pin_req && !cpu_i_bit;
    for (int i = 1; i < NSLOT; i++)
    begin
      // flags live in the sources and pend until cleared there
      pend[i] = periph_flag[i] && periph_en[i] && !cpu_i_bit;
    end
    // serial port: four events on one shared vector
    pend[`EVPC_SLOT_SCI] = pend[`EVPC_SLOT_SCI] ||
                           (|(sci_flag & sci_en) && !cpu_i_bit);
    // reserved vector slot never requests
    pend[evpc_slot_of(`EVPC_MASK_RSVD)] = 1'b0;
  end

  evpc_prio_pick #(
    .NSLOT(NSLOT)
  ) u_pick (
    .pend(pend),
    .promo(st_r.prio),
    .hit(m_hit),
    .vec_lo(m_lo)
  );

  // only the x bit masks the nonmaskable pin
  assign nmi_act = !nonmaskable_request_pin_n && !cpu_x_bit;
  assign pin_clr = st_r.seq == SEQ_HOLD && vec_done && st_r.sel_pin;

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  assign bus_req = avm_req.read || avm_req.write;
  assign wr_ack = avm_req.write && !st_r.waitreq && avm_req.byteenable[0];
  assign wd = avm_req.writedata[7:0];

  // read mux, unmapped offsets read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (avm_req.address)
      `EVPC_OFF_CTRL:
      begin
        rd_mux[`EVPC_BIT_EDGE] = st_r.edge_only;
        rd_mux[`EVPC_BIT_CONN] = st_r.connect;
        rd_mux[`EVPC_BIT_DLY] = st_r.dly;
      end
      `EVPC_OFF_PRIO:
      begin
        rd_mux[7:0] = st_r.prio;
      end
      `EVPC_OFF_STAT:
      begin
        rd_mux[4:0] = {st_r.osc_stable, st_r.seq == SEQ_HOLD,
                       pin_req, st_r.edge_wr_seen, st_r.dly_wr_seen};
      end
      default:
      begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    // one wait cycle, then a single ready cycle per request
    st_nxt.waitreq = !(bus_req && st_r.waitreq);
    if (avm_req.read && st_r.waitreq)
    begin
      st_nxt.rdata = rd_mux;
    end
    // control register writes
    if (wr_ack && avm_req.address == `EVPC_OFF_CTRL)
    begin
      // normal: first write only; special: all but the first
      if (special_mode ? st_r.edge_wr_seen : !st_r.edge_wr_seen)
      begin
        st_nxt.edge_only = wd[`EVPC_BIT_EDGE];
      end
      st_nxt.edge_wr_seen = 1'b1;
      st_nxt.connect = wd[`EVPC_BIT_CONN];
      if (special_mode || !st_r.dly_wr_seen)
      begin
        st_nxt.dly = wd[`EVPC_BIT_DLY];
      end
      st_nxt.dly_wr_seen = 1'b1;
    end
    // promotion register: ignored unless interrupts are inhibited
    if (wr_ack && avm_req.address == `EVPC_OFF_PRIO && cpu_i_bit)
    begin
      st_nxt.prio = wd;
    end
    // request line to the core
    st_nxt.int_req = nmi_act || m_hit;
    // vector hand-out
    unique case (st_r.seq)
      SEQ_IDLE:
      begin
        if (seq_start)
        begin
          st_nxt.seq = SEQ_HOLD;
          st_nxt.vec_valid = 1'b1;
          st_nxt.sel_pin = 1'b0;
          if (nmi_act)
          begin
            st_nxt.vec = `EVPC_VEC_NMI;
          end
          else if (m_hit)
          begin
            st_nxt.vec = {`EVPC_VEC_PAGE, m_lo};
            st_nxt.sel_pin = m_lo == `EVPC_MASK_TOP;
          end
          else
          begin
            // the source went away before the sequence began
            st_nxt.vec = `EVPC_VEC_TRAP;
          end
        end
      end
      SEQ_HOLD:
      begin
        // vector frozen until the core has fetched it
        if (vec_done)
        begin
          st_nxt.seq = SEQ_IDLE;
          st_nxt.vec_valid = 1'b0;
          st_nxt.sel_pin = 1'b0;
        end
      end
    endcase
    // oscillator settling on stop exit
    if (!st_r.osc_stable)
    begin
      st_nxt.dly_cnt = st_r.dly_cnt - 13'h0001;
      if (st_r.dly_cnt == 13'h0000)
      begin
        st_nxt.osc_stable = 1'b1;
      end
    end
    else if (stop_exit && st_r.dly)
    begin
      st_nxt.osc_stable = 1'b0;
      // low for exactly STOP_DLY cycles counted from the pulse edge
      st_nxt.dly_cnt = 13'(STOP_DLY - 1);
    end
    // reset cause caught once, on the first edge after release
    if (!st_r.booted)
    begin
      st_nxt.booted = 1'b1;
      st_nxt.rst_vec = rst_cause_clkmon ? `EVPC_VEC_CLKMON :
                       rst_cause_wdog ? `EVPC_VEC_WDOG :
                       `EVPC_VEC_RESET;
    end
  end

  // -----------------------------------------------------------------
  // state register; reset image sets prio f2 and normal vector
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_r <= ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign avm_readdata = st_r.rdata;
  assign avm_waitrequest = st_r.waitreq;
  assign int_req = st_r.int_req;
  assign vec_addr = st_r.vec;
  assign vec_valid = st_r.vec_valid;
  assign reset_vec = st_r.rst_vec;
  assign osc_stable = st_r.osc_stable;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_start_idle;
    seq_start && st_r.seq == SEQ_IDLE;
  endsequence

  sequence s_ctrl_wr;
    wr_ack && avm_req.address == `EVPC_OFF_CTRL;
  endsequence

  chk_prio_gate: assert property (
    wr_ack && avm_req.address == `EVPC_OFF_PRIO && !cpu_i_bit
    |=> $stable(st_r.prio))
    else $error("priority written while I bit clear");

  chk_vec_hold: assert property (
    vec_valid && !vec_done |=> vec_valid && $stable(vec_addr))
    else $error("vector changed before fetch done");

  chk_trap_empty: assert property (
    s_start_idle ##0 (!nmi_act && !m_hit) |=> vec_addr == `EVPC_VEC_TRAP)
    else $error("trap vector not taken");

  chk_nmi_vec: assert property (
    s_start_idle ##0 nmi_act |=> vec_valid && vec_addr == `EVPC_VEC_NMI)
    else $error("nonmaskable vector wrong");

  chk_masked_quiet: assert property (
    cpu_i_bit && !nmi_act |=> !int_req)
    else $error("request raised while I bit set");

  chk_edge_once: assert property (
    s_ctrl_wr ##0 (!special_mode && st_r.edge_wr_seen)
    |=> $stable(st_r.edge_only))
    else $error("edge select rewritten in normal mode");

  chk_edge_skip: assert property (
    s_ctrl_wr ##0 (special_mode && !st_r.edge_wr_seen)
    |=> $stable(st_r.edge_only) ##0 st_r.edge_wr_seen)
    else $error("first special edge select write taken");

  chk_stop_wait: assert property (
    stop_exit && st_r.dly && osc_stable |=> !osc_stable [*8])
    else $error("stop delay too short");

  chk_conn_off: assert property (
    !st_r.connect |-> !pin_req)
    else $error("disconnected pin still requests");

  chk_bus_ack: assert property (
    bus_req && avm_waitrequest |=> !avm_waitrequest ##1 avm_waitrequest)
    else $error("bus answer not one cycle");
endmodule : evpc_ctrl
`default_nettype wire

// ==== test/evpc_cpu_model.sv ====
// cpu core and external request logic facing the vector controller
`default_nettype none
module evpc_cpu_model
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic [3:0] hold_cyc,
  input wire logic ext_lvl,
  input wire logic ext_pulse,
  input wire logic vec_valid,
  input wire logic [15:0] vec_addr,
  output logic seq_start,
  output logic vec_done,
  output logic busy,
  output logic [15:0] first_vec,
  output logic [15:0] done_vec,
  output logic ext_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold_r; // requester keeps the pin low
  int n; // bounded wait for the vector
  // ---------------------------------------------------------------
  // level requester: lets go only after its handler acknowledged it
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      hold_r <= 1'b0;
    else if (ext_lvl)
      hold_r <= 1'b1;
    else if (vec_done && done_vec === 16'hfff2)
      hold_r <= 1'b0;
  end
  // pin has a pull-up, so released means high
  assign ext_request_n = !(hold_r || ext_pulse);
  // ---------------------------------------------------------------
  // cpu: start a sequence, take the vector, fetch slowly or promptly
  // ---------------------------------------------------------------
  initial
  begin
    seq_start = 1'b0;
    vec_done = 1'b0;
    busy = 1'b0;
    first_vec = 16'h0000;
    done_vec = 16'h0000;
    forever
    begin
      @(posedge core_clk);
      if (go && !sys_rst)
      begin
        busy <= 1'b1;
        seq_start <= 1'b1;
        @(posedge core_clk);
        seq_start <= 1'b0;
        n = 0;
        while (vec_valid !== 1'b1 && n < 20)
        begin
          @(posedge core_clk);
          n++;
        end
        first_vec <= vec_addr;
        // slow fetch: vector must not move meanwhile
        repeat (hold_cyc) @(posedge core_clk);
        done_vec <= vec_addr;
        vec_done <= 1'b1;
        @(posedge core_clk);
        vec_done <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule : evpc_cpu_model
`default_nettype wire

// ==== test/test_evpc_ctrl.sv ====
// self-checking bench of the exception vector controller
`default_nettype none
`include "evpc_map.svh"
module test_evpc_ctrl
  import evpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STOP_DLY = 16; // short stop-exit delay for sim
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  evpc_bus_req_t avm_req = '0;
  logic [31:0] avm_readdata;
  logic avm_waitrequest;
  logic special_mode = 1'b0;
  logic cpu_i_bit = 1'b1;
  logic cpu_x_bit = 1'b1;
  logic ext_request_n;
  logic nmi_n = 1'b1;
  logic [17:1] periph_flag = '0;
  logic [17:1] periph_en = '0;
  logic [3:0] sci_flag = 4'h0;
  logic [3:0] sci_en = 4'h0;
  logic seq_start;
  logic vec_done;
  logic stop_exit = 1'b0;
  logic cause_cm = 1'b0;
  logic cause_wd = 1'b0;
  logic int_req;
  logic vec_valid;
  logic osc_stable;
  logic [15:0] vec_addr;
  logic [15:0] reset_vec;
  logic go = 1'b0;
  logic [3:0] hold_cyc = 4'h0;
  logic ext_lvl = 1'b0;
  logic ext_pulse = 1'b0;
  logic busy;
  logic [15:0] first_vec;
  logic [15:0] done_vec;
  logic [31:0] rd; // last read data
  int cnt;
  int fail_count = 0;
  int compares = 0;
  // 200 mhz core clock
  always #2.5 core_clk = !core_clk;
  evpc_ctrl #(.STOP_DLY(STOP_DLY)) evpc_ctrl_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .avm_req(avm_req),
    .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
    .special_mode(special_mode), .cpu_i_bit(cpu_i_bit),
    .cpu_x_bit(cpu_x_bit), .ext_request_n(ext_request_n),
    .nonmaskable_request_pin_n(nmi_n), .periph_flag(periph_flag),
    .periph_en(periph_en), .sci_flag(sci_flag), .sci_en(sci_en),
    .seq_start(seq_start), .vec_done(vec_done), .stop_exit(stop_exit),
    .rst_cause_clkmon(cause_cm), .rst_cause_wdog(cause_wd),
    .int_req(int_req), .vec_addr(vec_addr), .vec_valid(vec_valid),
    .reset_vec(reset_vec), .osc_stable(osc_stable));
  evpc_cpu_model evpc_cpu_model_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .go(go),
    .hold_cyc(hold_cyc), .ext_lvl(ext_lvl), .ext_pulse(ext_pulse),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .seq_start(seq_start),
    .vec_done(vec_done), .busy(busy), .first_vec(first_vec),
    .done_vec(done_vec), .ext_request_n(ext_request_n));
  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("counts: compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic note(input logic bad, input logic [31:0] g,
                      input logic [31:0] e);
    compares++;
    if (bad !== 1'b0)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : note
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    note(g !== e, g, e);
  endtask : cmp_reg
  task automatic cmp_vec(input logic [15:0] g, input logic [15:0] e);
    note(g !== e, {16'h0000, g}, {16'h0000, e});
  endtask : cmp_vec
  task automatic cmp_bit(input logic g, input logic e);
    note(g !== e, {31'h0, g}, {31'h0, e});
  endtask : cmp_bit
  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // reset held 20 cycles; causes stay as levels past release
  task automatic do_reset(input logic sm, input logic cm,
                          input logic wd);
    sys_rst <= 1'b1;
    special_mode <= sm;
    cause_cm <= cm;
    cause_wd <= wd;
    cpu_i_bit <= 1'b1;
    tick(20);
    sys_rst <= 1'b0;
    tick(2);
  endtask : do_reset
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    avm_req.address <= a;
    avm_req.read <= !w;
    avm_req.write <= w;
    avm_req.byteenable <= 4'hf;
    avm_req.writedata <= {24'h000000, d};
    @(posedge core_clk);
    while (avm_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge core_clk);
      n++;
    end
    rd = avm_readdata;
    avm_req.read <= 1'b0;
    avm_req.write <= 1'b0;
    if (n >= 50) fail_count++;
    tick(1);
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    cmp_reg(rd, {24'h000000, e});
  endtask : rchk
  // one interrupt sequence; vector seen at start and at fetch end
  task automatic vchk(input logic [3:0] h, input logic [15:0] e);
    int n;
    n = 0;
    hold_cyc <= h;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(1);
    while (busy !== 1'b0 && n < 60)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 60) fail_count++;
    cmp_vec(first_vec, e);
    cmp_vec(done_vec, e);
  endtask : vchk
  task automatic stop_cnt(output int n);
    n = 0;
    stop_exit <= 1'b1;
    tick(1);
    stop_exit <= 1'b0;
    repeat (40)
    begin
      @(posedge core_clk);
      if (osc_stable === 1'b0) n++;
    end
  endtask : stop_cnt
  // ---------------------------------------------------------------
  // watchdog: whole run is a few hundred cycles
  // ---------------------------------------------------------------
  initial
  begin
    #100us;
    fail_count++;
    stop_test();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    do_reset(1'b0, 1'b0, 1'b0);
    cmp_vec(reset_vec, 16'hfffe);
    rchk(`EVPC_OFF_PRIO, 8'hf2);
    rchk(4'hc, 8'h00);
    rchk(`EVPC_OFF_STAT, 8'h10);
    $display("test reset done");
    // masked by the global bit, then by the local enable
    periph_flag[1] <= 1'b1;
    periph_en[1] <= 1'b1;
    tick(4);
    cmp_bit(int_req, 1'b0);
    vchk(4'h0, 16'hfff8);
    cpu_i_bit <= 1'b0;
    tick(4);
    cmp_bit(int_req, 1'b1);
    vchk(4'h0, 16'hfff0);
    periph_en[1] <= 1'b0;
    vchk(4'h0, 16'hfff8);
    $display("test masking done");
    periph_en[1] <= 1'b1;
    periph_flag[13] <= 1'b1;
    periph_en[13] <= 1'b1;
    wr(`EVPC_OFF_PRIO, 8'hd8);
    rchk(`EVPC_OFF_PRIO, 8'hf2);
    vchk(4'h0, 16'hfff0);
    cpu_i_bit <= 1'b1;
    wr(`EVPC_OFF_PRIO, 8'hd8);
    rchk(`EVPC_OFF_PRIO, 8'hd8);
    cpu_i_bit <= 1'b0;
    vchk(4'h5, 16'hffd8);
    nmi_n <= 1'b0;
    cpu_x_bit <= 1'b0;
    vchk(4'h0, 16'hfff4);
    cpu_x_bit <= 1'b1;
    vchk(4'h0, 16'hffd8);
    nmi_n <= 1'b1;
    cpu_i_bit <= 1'b1;
    periph_flag <= '0;
    $display("test priority done");
    // odd value would otherwise land on the serial slot
    wr(`EVPC_OFF_PRIO, 8'hd5);
    sci_flag[0] <= 1'b1;
    sci_en[0] <= 1'b1;
    ext_lvl <= 1'b1;
    tick(1);
    ext_lvl <= 1'b0;
    cpu_i_bit <= 1'b0;
    vchk(4'h2, 16'hfff2);
    vchk(4'h0, 16'hffd6);
    for (int k = 1; k < 4; k++)
    begin
      sci_flag <= 4'h1 << k;
      sci_en <= 4'h1 << k;
      vchk(4'h0, 16'hffd6);
    end
    sci_en <= 4'h0;
    vchk(4'h0, 16'hfff8);
    $display("test shared serial done");
    wr(`EVPC_OFF_CTRL, 8'hc0);
    rchk(`EVPC_OFF_CTRL, 8'hc0);
    rchk(`EVPC_OFF_STAT, 8'h13);
    ext_pulse <= 1'b1;
    tick(1);
    ext_pulse <= 1'b0;
    tick(10);
    vchk(4'h0, 16'hfff2);
    vchk(4'h0, 16'hfff8);
    wr(`EVPC_OFF_CTRL, 8'h20);
    rchk(`EVPC_OFF_CTRL, 8'h80);
    ext_pulse <= 1'b1;
    tick(1);
    ext_pulse <= 1'b0;
    vchk(4'h0, 16'hfff8);
    wr(`EVPC_OFF_CTRL, 8'h40);
    rchk(`EVPC_OFF_CTRL, 8'hc0);
    stop_cnt(cnt);
    cmp_reg(32'(cnt), 32'h0);
    $display("test edge mode done");
    do_reset(1'b1, 1'b0, 1'b1);
    cmp_vec(reset_vec, 16'hfffa);
    rchk(`EVPC_OFF_PRIO, 8'hf2);
    wr(`EVPC_OFF_CTRL, 8'he0);
    rchk(`EVPC_OFF_CTRL, 8'h60);
    stop_cnt(cnt);
    cmp_reg(32'(cnt), 32'(STOP_DLY));
    wr(`EVPC_OFF_CTRL, 8'h80);
    rchk(`EVPC_OFF_CTRL, 8'h80);
    wr(`EVPC_OFF_CTRL, 8'h60);
    rchk(`EVPC_OFF_CTRL, 8'h60);
    do_reset(1'b0, 1'b1, 1'b1);
    cmp_vec(reset_vec, 16'hfffc);
    $display("test special mode done");
    stop_test();
  end
endmodule : test_evpc_ctrl
`default_nettype wire
